// File: common/rsnr_pkg.sv
package rsnr_pkg;

  // Register word indices and byte addresses (printed offset 0x26 is not a multiple of four)
  // Control shares the status index: writes reach control, reads show status
  localparam logic [7:0]  IDX_STATUS      = 8'h26;
  localparam logic [7:0]  IDX_CONTROL     = 8'h26;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'h27;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h28;
  localparam logic [7:0]  IDX_TIMER_CFG   = 8'h29;
  localparam logic [9:0]  ADDR_STATUS     = {IDX_STATUS, 2'b00};
  localparam logic [9:0]  ADDR_CONTROL    = {IDX_CONTROL, 2'b00};
  localparam logic [9:0]  ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0]  ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0]  ADDR_TIMER_CFG  = {IDX_TIMER_CFG, 2'b00};

  // Control register field positions
  localparam int CTL_EN_BIT   = 7;
  localparam int CTL_POL_BIT  = 6;
  localparam int CTL_CSEL_BIT = 5;
  localparam int CTL_CNT_LSB  = 0;
  localparam int CNT_W        = 5;

  // Status register field positions
  localparam int STS_LVL_BIT  = 7;
  localparam int STS_POL_BIT  = 6;
  localparam int STS_CSEL_BIT = 5;
  localparam int STS_OVF_BIT  = 4;

  // Timer config register field positions (own register)
  localparam int TCF_RUN_BIT  = 3;
  localparam int TCF_DIV_BIT  = 4;
  localparam int TCF_CK_LSB   = 0;

  // Reset values
  localparam logic [7:0]  CONTROL_RST     = 8'h1F;
  localparam logic [4:0]  CNT_MIN         = 5'h02;
  localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;
  localparam logic [4:0]  TIMER_CFG_RST   = 5'h00;

  // Interrupt event bits
  localparam int IRQ_EDGE_BIT = 0;
  localparam int IRQ_OVF_BIT  = 1;

  // Divider lengths, as log2 of core_clk cycles, and the timer code for the external pin clock
  localparam int DIV_SHORT_LOG2 = 8;
  localparam int DIV_LONG_LOG2  = 9;
  localparam int TC3_EXT_CODE   = 7;

  // Bus transfer type
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic       enable;
    logic       polarity;
    logic       clk_sel;
    logic [4:0] count;
  } rsnr_ctrl_t;

  // Packed so that div_stage is bit 4 and run is bit 3 of the register
  typedef struct packed {
    logic       div_stage;
    logic       run;
    logic [2:0] clk_code;
  } rsnr_tcfg_t;

endpackage

// File: hw/rsnr_tick_gen.sv
`timescale 1ns/1ps
// Filter clock enable: divided system clock or capture timer source tick
module rsnr_tick_gen (
  input  wire logic               core_clk,   // System clock
  input  wire logic               srst,       // Sync reset, active high
  input  wire logic               enable,     // Receiver enabled
  input  wire logic               clk_sel,    // 0 divider, 1 timer source
  input  wire rsnr_pkg::rsnr_tcfg_t tcfg,     // Timer source settings
  output logic                    tick        // One-cycle filter tick
);

  logic [13:0] div_cnt;
  logic [13:0] next_div_cnt;
  logic        next_tick;

  // Timer prescale exponent: code 0 gives 2^13, code 6 gives 2^7
  function automatic logic [13:0] tc_mask(input logic [2:0] code, input logic stage);
    logic [3:0] e;
    e = 4'(4'd13 - {1'b0, code}) + {3'b000, stage};
    tc_mask = 14'((15'h0001 << e) - 15'h0001);
  endfunction

  // Free-running divider, held at zero while disabled
  always_comb
  begin
    logic [13:0] mask;
    mask = '0;
    if (!clk_sel)
      mask = tcfg.div_stage ? 14'((1 << rsnr_pkg::DIV_LONG_LOG2) - 1)
                            : 14'((1 << rsnr_pkg::DIV_SHORT_LOG2) - 1);
    else
      mask = tc_mask(tcfg.clk_code, tcfg.div_stage);
    next_div_cnt = enable ? div_cnt + 14'h0001 : 14'h0000;
    // External pin clock is not a legal filter source; no tick then
    next_tick = enable && ((div_cnt & mask) == mask)
                && !(clk_sel && tcfg.clk_code == 3'(rsnr_pkg::TC3_EXT_CODE));
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      div_cnt <= 14'h0000;
      tick    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

endmodule

// File: hw/rsnr_reject.sv
`timescale 1ns/1ps
// Debounce core: output follows input only after a stable run of ticks
module rsnr_reject (
  input  wire logic       core_clk,   // System clock
  input  wire logic       srst,       // Sync reset, active high
  input  wire logic       enable,     // Receiver enabled
  input  wire logic       tick,       // Filter clock enable
  input  wire logic       din,        // Polarity-corrected input
  input  wire logic [4:0] count,      // Reject count
  output logic            level,      // Filtered level
  output logic            ovf         // Counter ran past its limit
);

  logic [4:0] run_cnt;
  logic [4:0] next_run_cnt;
  logic       next_level;
  logic       next_ovf;

  // Limit is count-1 ticks of stable input, or 1 for counts below CNT_MIN
  always_comb
  begin
    logic [4:0] lim;
    lim          = (count < rsnr_pkg::CNT_MIN) ? 5'h01 : 5'(count - 5'h01);
    next_run_cnt = run_cnt;
    next_level   = level;
    next_ovf     = ovf;
    if (!enable)
    begin
      next_run_cnt = 5'h00;
      next_level   = 1'b0;
      next_ovf     = 1'b0;
    end
    else if (din == level)
      next_run_cnt = 5'h00;
    else if (tick)
    begin
      // Overflow when the limit was changed below a running count
      if (run_cnt >= lim)
      begin
        next_ovf     = run_cnt > lim;
        next_level   = din;
        next_run_cnt = 5'h00;
      end
      else
        next_run_cnt = run_cnt + 5'h01;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      run_cnt <= 5'h00;
      level   <= 1'b0;
      ovf     <= 1'b0;
    end
    else
    begin
      run_cnt <= next_run_cnt;
      level   <= next_level;
      ovf     <= next_ovf;
    end
  end

endmodule

// File: hw/rsnr_top.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module rsnr_top (
  input  wire logic        core_clk,     // System clock, 100 MHz
  input  wire logic        srst,         // Sync reset, active high
  input  wire logic        hsel,         // AHB slave select
  input  wire logic [31:0] haddr,        // AHB address
  input  wire logic [1:0]  htrans,       // AHB transfer type
  input  wire logic        hwrite,       // AHB write
  input  wire logic [2:0]  hsize,        // AHB size
  input  wire logic [31:0] hwdata,       // AHB write data
  input  wire logic        hready,       // AHB bus ready
  output logic [31:0]      hrdata,       // AHB read data
  output logic             hreadyout,    // AHB slave ready
  output logic             hresp,        // AHB response
  input  wire logic        remote_pin,   // Remote signal pin, async
  output logic             cap_level,    // Filtered level to capture timer
  output logic             cap_rise,     // Filtered rising edge pulse
  output logic             cap_fall,     // Filtered falling edge pulse
  output logic             irq           // Level interrupt
);

  rsnr_pkg::rsnr_ctrl_t ctrl;
  rsnr_pkg::rsnr_ctrl_t next_ctrl;
  rsnr_pkg::rsnr_tcfg_t tcfg;
  rsnr_pkg::rsnr_tcfg_t next_tcfg;
  logic [1:0]  irq_mask;
  logic [1:0]  next_irq_mask;
  logic [1:0]  irq_stat;
  logic [1:0]  next_irq_stat;
  logic        dp_wr;
  logic        dp_rd;
  logic [9:0]  dp_addr;
  logic        next_dp_wr;
  logic        next_dp_rd;
  logic [9:0]  next_dp_addr;
  logic [31:0] next_hrdata;
  logic        pin_s1;
  logic        pin_s2;
  logic        tick;
  logic        level;
  logic        ovf;
  logic        level_q;
  logic        ovf_q;
  logic        next_cap_rise;
  logic        next_cap_fall;
  logic        din;

  // Address phase capture; always zero-wait, always OKAY
  always_comb
  begin
    logic take;
    take         = hsel && hready && (htrans == rsnr_pkg::HTRANS_NONSEQ);
    next_dp_wr   = take && hwrite;
    next_dp_rd   = take && !hwrite;
    next_dp_addr = take ? haddr[9:0] : dp_addr;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Register writes in data phase; control is write-only except echoed bits
  always_comb
  begin
    next_ctrl     = ctrl;
    next_tcfg     = tcfg;
    next_irq_mask = irq_mask;
    if (dp_wr)
    begin
      unique case (dp_addr)
        rsnr_pkg::ADDR_CONTROL:
        begin
          next_ctrl.enable   = hwdata[rsnr_pkg::CTL_EN_BIT];
          next_ctrl.polarity = hwdata[rsnr_pkg::CTL_POL_BIT];
          next_ctrl.clk_sel  = hwdata[rsnr_pkg::CTL_CSEL_BIT];
          next_ctrl.count    = hwdata[rsnr_pkg::CTL_CNT_LSB +: rsnr_pkg::CNT_W];
        end
        rsnr_pkg::ADDR_TIMER_CFG:
          next_tcfg = hwdata[4:0];
        rsnr_pkg::ADDR_IRQ_MASK:
          next_irq_mask = hwdata[1:0];
        default:
          next_ctrl = ctrl;
      endcase
    end
  end

  // Read data; status word shows level, polarity, clock select, overflow
  always_comb
  begin
    next_hrdata = 32'h00000000;
    if (next_dp_rd)
    begin
      unique case (next_dp_addr)
        rsnr_pkg::ADDR_STATUS:
        begin
          next_hrdata[rsnr_pkg::STS_LVL_BIT]  = level;
          next_hrdata[rsnr_pkg::STS_POL_BIT]  = ctrl.polarity;
          next_hrdata[rsnr_pkg::STS_CSEL_BIT] = ctrl.clk_sel;
          next_hrdata[rsnr_pkg::STS_OVF_BIT]  = ovf;
        end
        rsnr_pkg::ADDR_IRQ_MASK:
          next_hrdata[1:0] = irq_mask;
        rsnr_pkg::ADDR_IRQ_STATUS:
          next_hrdata[1:0] = irq_stat;
        rsnr_pkg::ADDR_TIMER_CFG:
          next_hrdata[4:0] = tcfg;
        default:
          next_hrdata = 32'h00000000;
      endcase
    end
  end

  // Sticky events; read clears, a new event in that cycle wins
  always_comb
  begin
    logic [1:0] ev;
    ev = 2'b00;
    ev[rsnr_pkg::IRQ_EDGE_BIT] = next_cap_rise || next_cap_fall;
    ev[rsnr_pkg::IRQ_OVF_BIT]  = ovf && !ovf_q;
    next_irq_stat = irq_stat;
    if (next_dp_rd && next_dp_addr == rsnr_pkg::ADDR_IRQ_STATUS)
      next_irq_stat = 2'b00;
    next_irq_stat = next_irq_stat | ev;
  end

  assign irq = |(irq_stat & irq_mask);

  // Bus and config registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      dp_wr    <= 1'b0;
      dp_rd    <= 1'b0;
      dp_addr  <= 10'h000;
      hrdata   <= 32'h00000000;
      ctrl     <= rsnr_pkg::CONTROL_RST;
      tcfg     <= rsnr_pkg::TIMER_CFG_RST;
      irq_mask <= rsnr_pkg::IRQ_MASK_RST;
      irq_stat <= 2'h0;
    end
    else
    begin
      dp_wr    <= next_dp_wr;
      dp_rd    <= next_dp_rd;
      dp_addr  <= next_dp_addr;
      hrdata   <= next_hrdata;
      ctrl     <= next_ctrl;
      tcfg     <= next_tcfg;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
    end
  end

  // Pin synchroniser; only pin_s2 feeds logic
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= remote_pin;
      pin_s2 <= pin_s1;
    end
  end

  // Negative polarity inverts before the filter
  assign din = pin_s2 ^ ctrl.polarity;

  // Filter clock source select
  rsnr_tick_gen u_tick (
    .core_clk (core_clk),
    .srst     (srst),
    .enable   (ctrl.enable),
    .clk_sel  (ctrl.clk_sel),
    .tcfg     (tcfg),
    .tick     (tick)
  );

  // Stable-run debounce
  rsnr_reject u_rej (
    .core_clk (core_clk),
    .srst     (srst),
    .enable   (ctrl.enable),
    .tick     (tick),
    .din      (din),
    .count    (ctrl.count),
    .level    (level),
    .ovf      (ovf)
  );

  // Edge pulses to the capture timer, only while enabled
  assign next_cap_rise = level && !level_q && ctrl.enable;
  assign next_cap_fall = !level && level_q && ctrl.enable;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      level_q   <= 1'b0;
      ovf_q     <= 1'b0;
      cap_level <= 1'b0;
      cap_rise  <= 1'b0;
      cap_fall  <= 1'b0;
    end
    else
    begin
      level_q   <= level;
      ovf_q     <= ovf;
      cap_level <= level;
      cap_rise  <= next_cap_rise;
      cap_fall  <= next_cap_fall;
    end
  end

  // Disabled receiver keeps the filter output low
  property p_idle_when_off;
    @(posedge core_clk) disable iff (srst)
      !ctrl.enable |=> !level;
  endproperty
  a_idle_when_off: assert property (p_idle_when_off)
    else $error("filter not idle while disabled");

  // No edge pulses two cycles into a disabled stretch
  property p_no_edges_off;
    @(posedge core_clk) disable iff (srst)
      !ctrl.enable ##1 !ctrl.enable |=> !cap_rise && !cap_fall;
  endproperty
  a_no_edges_off: assert property (p_no_edges_off)
    else $error("edge passed while disabled");

  // Level changes only on a tick, and only toward the input
  property p_change_on_tick;
    @(posedge core_clk) disable iff (srst)
      ctrl.enable && $past(ctrl.enable) && level != $past(level)
        |-> $past(tick) && level == $past(din);
  endproperty
  a_change_on_tick: assert property (p_change_on_tick)
    else $error("level changed without tick");

  // Rising edge to capture timer follows filtered level by one cycle
  property p_rise_tracks;
    @(posedge core_clk) disable iff (srst)
      $rose(level) && ctrl.enable |=> cap_rise ##1 cap_level;
  endproperty
  a_rise_tracks: assert property (p_rise_tracks)
    else $error("capture rise missed");

  // Status read returns level and overflow from the address phase
  property p_status_read;
    @(posedge core_clk) disable iff (srst)
      next_dp_rd && next_dp_addr == rsnr_pkg::ADDR_STATUS
        |=> hrdata[rsnr_pkg::STS_LVL_BIT] == $past(level)
            && hrdata[rsnr_pkg::STS_OVF_BIT] == $past(ovf);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status level or overflow wrong");

  // Polarity echoed in status
  property p_pol_echo;
    @(posedge core_clk) disable iff (srst)
      next_dp_rd && next_dp_addr == rsnr_pkg::ADDR_STATUS
        |=> hrdata[rsnr_pkg::STS_POL_BIT] == $past(ctrl.polarity);
  endproperty
  a_pol_echo: assert property (p_pol_echo)
    else $error("polarity not echoed");

  // Overflow rise sets sticky status
  property p_ovf_sticky;
    @(posedge core_clk) disable iff (srst)
      $rose(ovf) |=> irq_stat[rsnr_pkg::IRQ_OVF_BIT];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow event lost");

  // No second tick 8 cycles after a tick with short divider
  property p_div_spacing;
    @(posedge core_clk) disable iff (srst)
      tick && ctrl.enable && !ctrl.clk_sel && !tcfg.div_stage
        && !dp_wr ##1 ctrl.enable[*8] |-> !tick;
  endproperty
  a_div_spacing: assert property (p_div_spacing)
    else $error("divider tick too soon");

  // Control write lands in one cycle
  property p_ctrl_write;
    @(posedge core_clk) disable iff (srst)
      dp_wr && dp_addr == rsnr_pkg::ADDR_CONTROL
        |=> ctrl.count == $past(hwdata[4:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("reject count not written");

endmodule

// File: tb/rsnr_remote_src.sv
`timescale 1ns/1ps
// Remote receiver module output, idles high through its pull-up
module rsnr_remote_src (
  input  wire logic core_clk, // System clock
  output logic      pin       // Demodulated remote signal
);
  initial pin = 1'b1;

  // Change the level just after an edge, then hold it for n clocks
  task automatic drive(input logic lvl, input int n);
    @(posedge core_clk);
    pin <= lvl;
    repeat (n) @(posedge core_clk);
  endtask
endmodule

// File: tb/tb_remote_signal_noise_rejecter.sv
`timescale 1ns/1ps
module tb_remote_signal_noise_rejecter;
  logic        core_clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        remote_pin;
  logic        cap_level;
  logic        cap_rise;
  logic        cap_fall;
  logic        irq;
  int          n_errors;
  int          checks_done;
  int          cyc;
  int          n_rise;
  int          n_fall;
  int          exp_rise;
  int          seed;
  logic [31:0] rd;

  rsnr_top dut (
    .core_clk  (core_clk),
    .srst      (srst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'h2),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .remote_pin(remote_pin),
    .cap_level (cap_level),
    .cap_rise  (cap_rise),
    .cap_fall  (cap_fall),
    .irq       (irq)
  );

  rsnr_remote_src src (
    .core_clk(core_clk),
    .pin     (remote_pin)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Edge counters and hang guard; counting keeps the one-cycle pulses from being missed
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cap_rise === 1'b1) n_rise = n_rise + 1;
    if (cap_fall === 1'b1) n_fall = n_fall + 1;
    if (cyc == 60000)
    begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // One single AHB-Lite transfer; hreadyout is awaited in both phases
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {22'h000000, a};
    htrans <= rsnr_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {$random(seed) & 32'hFFFFFF00} | {24'h000000, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Control: enable, polarity, clock select, reject count; never read back
  task automatic ctl(input logic en, input logic pol, input logic cs, input logic [4:0] c);
    bus(1'b1, rsnr_pkg::ADDR_CONTROL, {en, pol, cs, c});
  endtask

  // Wait for the filtered level, then check how long it took after the cause
  task automatic wait_lvl(input logic exp, input int lo, input int hi);
    int n;
    n = 0;
    while (cap_level !== exp && n <= hi)
    begin
      @(posedge core_clk);
      n = n + 1;
    end
    chk("cap_level", exp, cap_level);
    chk("settle_in_window", 1, (n >= lo && n <= hi));
    @(posedge core_clk); // Let the edge counters take the last pulse
  endtask

  initial
  begin
    seed = 8668;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    n_rise = 0;
    n_fall = 0;
    exp_rise = 0;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    // Reset state and an unmapped address
    bus(1'b0, rsnr_pkg::ADDR_STATUS, 8'h00);
    chk("status_rst", 32'h00, rd & 32'hF0);
    bus(1'b0, 10'h000, 8'h00);
    chk("unmapped", 32'h00, rd);
    chk("hresp", 1'b0, hresp);
    $display("Test reset done");
    // Disabled receiver ignores a high pin
    repeat (1000) @(posedge core_clk);
    chk("disabled_level", 1'b0, cap_level);
    $display("Test disabled done");
    // Enable with count 2: two divided ticks of 256 clocks each
    bus(1'b1, rsnr_pkg::ADDR_IRQ_MASK, 8'h00);
    ctl(1'b1, 1'b0, 1'b0, 5'h02);
    wait_lvl(1'b1, 256, 2 * 256 + 8);
    exp_rise = exp_rise + 1;
    bus(1'b0, rsnr_pkg::ADDR_STATUS, 8'h00);
    chk("status_lvl", 32'h80, rd & 32'hF0);
    chk("irq_masked", 1'b0, irq);
    bus(1'b1, rsnr_pkg::ADDR_IRQ_MASK, 8'h01);
    @(posedge core_clk); // Mask register lands at the data-phase edge
    chk("irq_on", 1'b1, irq);
    bus(1'b0, rsnr_pkg::ADDR_IRQ_STATUS, 8'h00);
    chk("irq_stat", 32'h01, rd & 32'h01);
    chk("irq_cleared", 1'b0, irq);
    $display("Test enable done");
    // Count 4 rejects for three ticks; random glitches under one tick
    ctl(1'b1, 1'b0, 1'b0, 5'h04);
    n_fall = 0;
    repeat (6)
    begin
      src.drive(1'b0, 1 + ({$random(seed)} % 200));
      src.drive(1'b1, 300);
    end
    chk("glitch_level", 1'b1, cap_level);
    chk("glitch_falls", 0, n_fall);
    src.drive(1'b0, 0);
    wait_lvl(1'b0, 3 * 256, 4 * 256 + 8);
    chk("falls", 1, n_fall);
    $display("Test reject done");
    // Negative polarity: low pin reads as high
    ctl(1'b1, 1'b1, 1'b0, 5'h02);
    wait_lvl(1'b1, 256, 2 * 256 + 8);
    exp_rise = exp_rise + 1;
    bus(1'b0, rsnr_pkg::ADDR_STATUS, 8'h00);
    chk("status_pol", 32'hC0, rd & 32'hF0);
    $display("Test polarity done");
    // Timer source clock, code 6 gives 128 clocks per tick, timer stopped
    bus(1'b1, rsnr_pkg::ADDR_TIMER_CFG, 8'h06);
    ctl(1'b1, 1'b0, 1'b1, 5'h03);
    wait_lvl(1'b0, 2 * 128, 3 * 128 + 8);
    bus(1'b0, rsnr_pkg::ADDR_STATUS, 8'h00);
    chk("status_csel", 32'h20, rd & 32'hF0);
    $display("Test timer clock done");
    // Lowering the count under a running stable count overflows the filter
    ctl(1'b1, 1'b0, 1'b1, 5'h04);
    src.drive(1'b1, 2 * 128 + 64);
    ctl(1'b1, 1'b0, 1'b1, 5'h02);
    repeat (140) @(posedge core_clk);
    exp_rise = exp_rise + 1;
    bus(1'b0, rsnr_pkg::ADDR_STATUS, 8'h00);
    chk("status_ovf", 32'hB0, rd & 32'hF0);
    bus(1'b0, rsnr_pkg::ADDR_IRQ_STATUS, 8'h00);
    chk("irq_ovf", 32'h02, rd & 32'h02);
    $display("Test overflow done");
    // Long divider stage: 512 clocks per tick
    bus(1'b1, rsnr_pkg::ADDR_TIMER_CFG, 8'h10);
    ctl(1'b1, 1'b0, 1'b0, 5'h02);
    src.drive(1'b0, 0);
    wait_lvl(1'b0, 512, 2 * 512 + 8);
    chk("rises", exp_rise, n_rise);
    $display("Test long divider done");
    // Disabling clears the filter; a high pin would otherwise rise in time
    src.drive(1'b1, 0);
    ctl(1'b0, 1'b0, 1'b0, 5'h02);
    wait_lvl(1'b0, 0, 8);
    repeat (1100) @(posedge core_clk);
    chk("off_rises", exp_rise, n_rise);
    $display("Test disable done");
    end_of_test();
  end
endmodule
